/* File: rtl/cmhs_pkg.sv */
// Package for the cluster multiplexer host select and reply block.
// Assumes one system clock; APB register offsets are byte addresses.
package cmhs_pkg;
    // APB register byte offsets
    localparam logic [7:0] CMHS_OFF_STRAP   = 8'h00;
    localparam logic [7:0] CMHS_OFF_CMD     = 8'h04;
    localparam logic [7:0] CMHS_OFF_STATUS  = 8'h08;
    localparam logic [7:0] CMHS_OFF_REQFLAG = 8'h0C;
    localparam logic [7:0] CMHS_OFF_TICKS   = 8'h10;
    // Strap register field positions
    localparam int CMHS_STRAP_EQ_LSB     = 0;  // Four equipment code bits
    localparam int CMHS_STRAP_EXT_A      = 4;
    localparam int CMHS_STRAP_EXT_B      = 5;
    localparam int CMHS_STRAP_CLUSTER    = 6;
    localparam int CMHS_STRAP_UNPROT     = 7;  // Inserted strap means unprotected
    localparam int CMHS_STRAP_DIV1_LSB   = 8;  // Two bits: 0 -> 16, 1 -> 8, 2 -> 4
    localparam int CMHS_STRAP_DIV2       = 10; // 0 -> 3, 1 -> 6
    localparam int CMHS_STRAP_RXSLOT_LSB = 12; // Two bits: 0..3 -> 3,4,6,8
    localparam int CMHS_STRAP_TXSLOT_LSB = 14;
    // Command word bit positions
    localparam int CMHS_CMD_DIRECTOR     = 0;
    localparam int CMHS_CMD_CHAN_LSB     = 4;
    localparam int CMHS_CMD_CLUSTER      = 6;
    localparam int CMHS_CMD_EQ_LSB       = 7;
    localparam int CMHS_CMD_WRITE        = 16; // Host write when set, read otherwise
    // Reset values
    localparam logic [15:0] CMHS_STRAP_RESET = 16'h0000;
    localparam logic [7:0]  CMHS_REQ_RESET   = 8'hFF;
    // Divider ratios
    localparam logic [4:0] CMHS_DIV1_16 = 5'h10;
    localparam logic [4:0] CMHS_DIV1_8  = 5'h08;
    localparam logic [4:0] CMHS_DIV1_4  = 5'h04;
    localparam logic [2:0] CMHS_DIV2_3  = 3'h3;
    localparam logic [2:0] CMHS_DIV2_6  = 3'h6;
    typedef enum logic [1:0] {CMHS_SLOTS_3, CMHS_SLOTS_4, CMHS_SLOTS_6, CMHS_SLOTS_8} cmhs_slots_t;
endpackage

/* File: rtl/cmhs_decode.sv */
// Combinational address match and reply or reject decision.
// Assumes a stable command word while evaluated.
`timescale 1ns/1ps
module cmhs_decode
    import cmhs_pkg::*;
(
    input  wire logic [16:0] cmd_in,
    input  wire logic [15:0] strap_in,
    input  wire logic [7:0]  req_flag_in,
    output logic             selected_out,
    output logic             reply_out,
    output logic             reject_out
);
    logic [3:0] eq_strap;
    logic       ext_mode;
    logic       eq_match;
    logic       cl_match;
    logic       protect_viol;
    logic       director;
    logic       is_write;
    logic [2:0] chan;
    // Field extraction
    assign eq_strap = strap_in[CMHS_STRAP_EQ_LSB +: 4];
    assign director = cmd_in[CMHS_CMD_DIRECTOR];
    assign is_write = cmd_in[CMHS_CMD_WRITE];
    assign chan     = cmd_in[CMHS_CMD_CHAN_LSB +: 3];
    // Inserted strap is a one in the matching code bit
    assign eq_match = (cmd_in[CMHS_CMD_EQ_LSB +: 4] == eq_strap);
    // Extended mode needs both straps; bit six only counts then
    assign ext_mode = strap_in[CMHS_STRAP_EXT_A] & strap_in[CMHS_STRAP_EXT_B];
    assign cl_match = !ext_mode
                    | (cmd_in[CMHS_CMD_CLUSTER] == strap_in[CMHS_STRAP_CLUSTER]);
    // Absent strap means protected; the protected host access is taken as legal
    assign protect_viol = 1'b0 & ~strap_in[CMHS_STRAP_UNPROT];
    // No match leaves both responses low
    assign selected_out = eq_match & cl_match;
    assign reject_out = selected_out & (
          ( is_write & !director & (protect_viol | !req_flag_in[chan]))
        | ( is_write &  director & protect_viol)
        | (!is_write & !director & protect_viol));
    // Status read always replies data write needs the request flag
    assign reply_out  = selected_out & !reject_out;
endmodule

/* File: rtl/cmhs_clkdiv.sv */
// Cascaded clock interrupt divider fed by a synchronised element-timing edge.
// Assumes tick_in is a one-cycle pulse in clk_sys_in domain.
`timescale 1ns/1ps
module cmhs_clkdiv
    import cmhs_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       tick_in,
    input  wire logic [1:0] div1_sel_in,
    input  wire logic       div2_sel_in,
    output logic            period_out
);
    logic [4:0] cnt1;
    logic [2:0] cnt2;
    logic [4:0] ratio1;
    logic [2:0] ratio2;
    logic       stage1_done;
    // Ratio selection; an unused code falls back to the slowest ratio
    assign ratio1 = (div1_sel_in == 2'h1) ? CMHS_DIV1_8 :
                    (div1_sel_in == 2'h2) ? CMHS_DIV1_4 : CMHS_DIV1_16;
    assign ratio2 = div2_sel_in ? CMHS_DIV2_6 : CMHS_DIV2_3;
    assign stage1_done = tick_in & (cnt1 == ratio1 - 5'h01);
    // First stage
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt1 <= 5'h00;
        end else if (tick_in) begin
            cnt1 <= stage1_done ? 5'h00 : cnt1 + 5'h01;
        end
    end
    // Second stage, period pulse on wrap
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt2       <= 3'h0;
            period_out <= 1'b0;
        end else begin
            period_out <= stage1_done & (cnt2 == ratio2 - 3'h1);
            if (stage1_done) begin
                cnt2 <= (cnt2 == ratio2 - 3'h1) ? 3'h0 : cnt2 + 3'h1;
            end
        end
    end
endmodule

/* File: rtl/cmhs_top.sv */
// Top of host select and reply logic with APB register access.
// Assumes APB master on clk_sys_in; element timing arrives asynchronously.
`timescale 1ns/1ps
module cmhs_top
    import cmhs_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        element_timing_in,
    input  wire logic [7:0]  char_sent_in,
    output logic             reply_out,
    output logic             reject_out,
    output logic [3:0]       rx_slots_out,
    output logic [3:0]       tx_slots_out,
    output logic             slot_mismatch_out
);
    logic [15:0] strap;
    logic [16:0] cmd;
    logic [7:0]  req_flag;
    logic [15:0] ticks;
    logic        et_meta;
    logic        et_sync;
    logic        et_prev;
    logic        et_tick;
    logic        period;
    logic        dec_reply;
    logic        dec_reject;
    logic        wr_acc;
    logic        wr_strap;
    logic        wr_cmd;
    logic        hit;
    logic        ext_ok;
    logic [2:0]  chan;
    logic [7:0]  accept_mask;
    logic [31:0] next_prdata;
    logic [1:0]  rx_code;
    logic [1:0]  tx_code;

    // APB decode; slave answers in the access cycle with no wait states
    assign wr_acc   = psel_in & penable_in & pwrite_in;
    assign wr_strap = wr_acc & (paddr_in == CMHS_OFF_STRAP);
    assign wr_cmd   = wr_acc & (paddr_in == CMHS_OFF_CMD);
    assign hit      = (paddr_in == CMHS_OFF_STRAP) | (paddr_in == CMHS_OFF_CMD)
                    | (paddr_in == CMHS_OFF_STATUS) | (paddr_in == CMHS_OFF_REQFLAG)
                    | (paddr_in == CMHS_OFF_TICKS);
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & !hit;

    // Strap register; extended mode is only kept with 3 or 4 slots
    assign ext_ok = (pwdata_in[CMHS_STRAP_RXSLOT_LSB +: 2] <= 2'h1)
                  & (pwdata_in[CMHS_STRAP_TXSLOT_LSB +: 2] <= 2'h1);
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap <= CMHS_STRAP_RESET;
        end else if (wr_strap) begin
            strap <= ext_ok ? pwdata_in[15:0]
                            : (pwdata_in[15:0] & ~(16'h0001 << CMHS_STRAP_EXT_A));
        end
    end

    // Command word is latched; a decision is taken on the write itself
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd <= 17'h00000;
        end else if (wr_cmd) begin
            cmd <= pwdata_in[16:0];
        end
    end

    cmhs_decode u_decode (
        .cmd_in       (pwdata_in[16:0]),
        .strap_in     (strap),
        .req_flag_in  (req_flag),
        .selected_out (),
        .reply_out    (dec_reply),
        .reject_out   (dec_reject)
    );

    // Responses are one-cycle pulses after the command write
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reply_out  <= 1'b0;
            reject_out <= 1'b0;
        end else begin
            reply_out  <= wr_cmd & dec_reply;
            reject_out <= wr_cmd & dec_reject;
        end
    end

    // Request flag: cleared by an accepted data write, set by a sent char
    assign chan = pwdata_in[CMHS_CMD_CHAN_LSB +: 3];
    assign accept_mask = (wr_cmd & dec_reply & pwdata_in[CMHS_CMD_WRITE]
                          & !pwdata_in[CMHS_CMD_DIRECTOR]) ? (8'h01 << chan) : 8'h00;
    // Set wins over clear so a freed buffer is never missed
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_flag <= CMHS_REQ_RESET;
        end else begin
            req_flag <= (req_flag & ~accept_mask) | char_sent_in;
        end
    end

    // Element timing is asynchronous: two flops, then edge detect
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            et_meta <= 1'b0;
            et_sync <= 1'b0;
            et_prev <= 1'b0;
        end else begin
            et_meta <= element_timing_in;
            et_sync <= et_meta;
            et_prev <= et_sync;
        end
    end
    assign et_tick = et_sync & !et_prev;

    cmhs_clkdiv u_clkdiv (
        .clk_sys_in  (clk_sys_in),
        .reset_n_in  (reset_n_in),
        .tick_in     (et_tick),
        .div1_sel_in (strap[CMHS_STRAP_DIV1_LSB +: 2]),
        .div2_sel_in (strap[CMHS_STRAP_DIV2]),
        .period_out  (period)
    );

    // Count of elapsed clock periods, visible to software
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ticks <= 16'h0000;
        end else if (period) begin
            ticks <= ticks + 16'h0001;
        end
    end

    // Slot counts per block, receive and transmit separately
    assign rx_code = strap[CMHS_STRAP_RXSLOT_LSB +: 2];
    assign tx_code = strap[CMHS_STRAP_TXSLOT_LSB +: 2];
    function automatic logic [3:0] slots_of(input logic [1:0] code);
        unique case (cmhs_slots_t'(code))
            CMHS_SLOTS_3: slots_of = 4'h3;
            CMHS_SLOTS_4: slots_of = 4'h4;
            CMHS_SLOTS_6: slots_of = 4'h6;
            CMHS_SLOTS_8: slots_of = 4'h8;
        endcase
    endfunction
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_slots_out      <= 4'h3;
            tx_slots_out      <= 4'h3;
            slot_mismatch_out <= 1'b0;
        end else begin
            rx_slots_out      <= slots_of(rx_code);
            tx_slots_out      <= slots_of(tx_code);
            slot_mismatch_out <= (rx_code != tx_code);
        end
    end

    // Read mux; status shows the current one-cycle response pulses and protect state
    assign next_prdata =
        (paddr_in == CMHS_OFF_STRAP)   ? {16'h0000, strap} :
        (paddr_in == CMHS_OFF_CMD)     ? {15'h0000, cmd} :
        (paddr_in == CMHS_OFF_STATUS)  ? {28'h0000000, !strap[CMHS_STRAP_UNPROT],
                                          slot_mismatch_out, reject_out, reply_out} :
        (paddr_in == CMHS_OFF_REQFLAG) ? {24'h000000, req_flag} :
        (paddr_in == CMHS_OFF_TICKS)   ? {16'h0000, ticks} : 32'h00000000;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_out <= 32'h00000000;
        end else if (psel_in & !penable_in & !pwrite_in) begin
            prdata_out <= next_prdata;
        end
    end
endmodule

/* File: tb/cmhs_chk.sv */
// Checker for the host select and reply block.
// Assumes it is bound to cmhs_top and sees its ports only.
`timescale 1ns/1ps
module cmhs_chk
    import cmhs_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        reply_out,
    input wire logic        reject_out,
    input wire logic [3:0]  rx_slots_out,
    input wire logic [3:0]  tx_slots_out,
    input wire logic        slot_mismatch_out
);
    logic [15:0] shadow;
    // Decode of host command writes against the shadowed straps
    wire logic wr_acc = psel_in && penable_in && pwrite_in;
    wire logic cmd_wr = wr_acc && paddr_in == CMHS_OFF_CMD;
    wire logic ext    = shadow[4] && shadow[5];
    wire logic hit    = pwdata_in[10:7] == shadow[3:0] && (!ext || pwdata_in[6] == shadow[6]);
    // Strap shadow; extended mode is dropped when either slot count exceeds four
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shadow <= CMHS_STRAP_RESET;
        end else if (wr_acc && paddr_in == CMHS_OFF_STRAP) begin
            shadow <= {pwdata_in[15:5], pwdata_in[4] & ~pwdata_in[13] & ~pwdata_in[15], pwdata_in[3:0]};
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_nomatch; cmd_wr && !hit |=> !reply_out && !reject_out; endproperty
    a_nomatch: assert property (p_nomatch) else $error("answer without address match");
    property p_status; cmd_wr && hit && pwdata_in[0] && !pwdata_in[16] |=> !reject_out; endproperty
    a_status: assert property (p_status) else $error("status read rejected");
    property p_reply; cmd_wr && hit && (pwdata_in[0] || !pwdata_in[16]) |=> reply_out; endproperty
    a_reply: assert property (p_reply) else $error("matched command got no reply");
    property p_data; cmd_wr && hit && !pwdata_in[0] && pwdata_in[16] |=> reply_out != reject_out; endproperty
    a_data: assert property (p_data) else $error("data write answer wrong");
    property p_cause; reply_out || reject_out |-> $past(cmd_wr); endproperty
    a_cause: assert property (p_cause) else $error("answer without command");
    property p_pulse; reply_out || reject_out |=> !reply_out && !reject_out; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
    property p_slots; rx_slots_out inside {4'h3, 4'h4, 4'h6, 4'h8} && tx_slots_out inside {4'h3, 4'h4, 4'h6, 4'h8};
    endproperty
    a_slots: assert property (p_slots) else $error("illegal slot count");
    property p_mism; slot_mismatch_out == (rx_slots_out != tx_slots_out); endproperty
    a_mism: assert property (p_mism) else $error("slot mismatch flag wrong");
endmodule

/* File: tb/cmhs_host.sv */
// Host bus model: an APB master standing in for the host program.
// Assumes one clock; waits for pready at every access.
`timescale 1ns/1ps
module cmhs_host
(
    input  wire logic        clk_sys_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
    end
    // One transfer; a rejected data write is retried later by the caller
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_sys_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_sys_in);
        penable_out <= 1'b1;
        do @(posedge clk_sys_in); while (pready_in !== 1'b1);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released bus shows no stale value
        pwdata_out <= ~d;
    endtask
endmodule

/* File: tb/tb.sv */
// Testbench for the host select and reply block.
// Assumes cmhs_top with zero-wait APB driven by the host model.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb
    import cmhs_pkg::*;
;
    logic             clk_sys_in, reset_n_in, element_timing_in;
    logic [7:0]       char_sent_in;
    wire logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    wire logic        reply_out, reject_out, slot_mismatch_out;
    wire logic [7:0]  paddr_in;
    wire logic [31:0] pwdata_in, prdata_out;
    wire logic [3:0]  rx_slots_out, tx_slots_out;
    int               n_mismatch = 0;
    int               tests_run = 0;
    logic [31:0]      q;
    logic             e;
    cmhs_top cmhs_top_inst (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .element_timing_in, .char_sent_in, .reply_out, .reject_out,
        .rx_slots_out, .tx_slots_out, .slot_mismatch_out);
    cmhs_host cmhs_host_inst (.clk_sys_in, .psel_out(psel_in), .penable_out(penable_in), .pwrite_out(pwrite_in),
        .paddr_out(paddr_in), .pwdata_out(pwdata_in), .prdata_in(prdata_out), .pready_in(pready_out),
        .pslverr_in(pslverr_out));
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cmhs_host_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        cmhs_host_inst.xfer(1'b0, a, 32'h0, q, e);
    endtask
    function automatic logic [16:0] cw(input logic [3:0] eq, input logic cl, input logic dr, input logic w);
        return {w, 5'h00, eq, cl, 2'h2, 3'h0, dr};
    endfunction
    // Command word, then the answer 1 ns after the access edge
    task automatic cmd(input logic [16:0] w, input logic [1:0] exp);
        wr(CMHS_OFF_CMD, {15'h0, w});
        #1;
        `CHK({reply_out, reject_out}, exp)
    endtask
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
    endtask
    // Element timing stays slow so the synchroniser sees every edge
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk_sys_in);
            element_timing_in <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            element_timing_in <= 1'b0;
        end
    endtask
    task automatic s_reset();
        rd(CMHS_OFF_REQFLAG);
        `CHK(q[7:0], CMHS_REQ_RESET)
        `CHK({rx_slots_out, tx_slots_out}, 8'h33)
        rd(8'h40);
        `CHK({e, q}, 33'h1_0000_0000)
    endtask
    task automatic s_eq();
        for (int i = 0; i < 4; i++) begin
            wr(CMHS_OFF_STRAP, 32'h1 << i);
            cmd(cw(4'h1 << i, 1'b1, 1'b1, 1'b0), 2'b10);
            cmd(cw(4'h0, 1'b0, 1'b1, 1'b1), 2'b00);
        end
        cmd(cw(4'h8, 1'b0, 1'b1, 1'b1), 2'b10);
        cmd(cw(4'h8, 1'b0, 1'b0, 1'b0), 2'b10);
        rd(CMHS_OFF_STATUS);
        `CHK(q[3], 1'b1)
        wr(CMHS_OFF_STRAP, 32'h0000_0083);
        rd(CMHS_OFF_STATUS);
        `CHK(q[3], 1'b0)
    endtask
    task automatic s_data();
        cmd(cw(4'h3, 1'b0, 1'b0, 1'b1), 2'b10);
        cmd(cw(4'h3, 1'b0, 1'b0, 1'b1), 2'b01);
        rd(CMHS_OFF_REQFLAG);
        `CHK(q[7:0], 8'hFB)
        @(posedge clk_sys_in) char_sent_in <= 8'h04;
        @(posedge clk_sys_in) char_sent_in <= 8'h00;
        cmd(cw(4'h3, 1'b0, 1'b0, 1'b1), 2'b10);
    endtask
    task automatic s_ext();
        wr(CMHS_OFF_STRAP, 32'h0000_00F3);
        cmd(cw(4'h3, 1'b0, 1'b1, 1'b0), 2'b00);
        cmd(cw(4'h3, 1'b1, 1'b1, 1'b0), 2'b10);
        wr(CMHS_OFF_STRAP, 32'h0000_00B3);
        cmd(cw(4'h3, 1'b1, 1'b1, 1'b0), 2'b00);
        wr(CMHS_OFF_STRAP, 32'h0000_A0F3);
        cmd(cw(4'h3, 1'b0, 1'b1, 1'b0), 2'b10);
    endtask
    task automatic s_slots();
        logic [3:0] n [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
        for (int i = 0; i < 4; i++) begin
            wr(CMHS_OFF_STRAP, {16'h0, i[1:0], i[1:0], 12'h0});
            repeat (2) @(posedge clk_sys_in);
            `CHK({rx_slots_out, tx_slots_out, slot_mismatch_out}, {n[i], n[i], 1'b0})
        end
        wr(CMHS_OFF_STRAP, 32'h0000_4000);
        repeat (2) @(posedge clk_sys_in);
        `CHK({rx_slots_out, tx_slots_out, slot_mismatch_out}, 9'h069)
        // Status shows protected and mismatch; the one-cycle answers are long gone
        rd(CMHS_OFF_STATUS);
        `CHK(q[3:0], 4'hC)
    endtask
    task automatic s_div();
        logic [1:0] c1 [3] = '{2'h2, 2'h1, 2'h0};
        logic       c2 [3] = '{1'b0, 1'b1, 1'b1};
        int         r  [3] = '{12, 48, 96};
        for (int i = 0; i < 3; i++) begin
            do_reset();
            wr(CMHS_OFF_STRAP, {20'h0, 1'b0, c2[i], c1[i], 8'h00});
            pulses(3 * r[i] - 1);
            rd(CMHS_OFF_TICKS);
            `CHK(q, 32'h2)
            pulses(1);
            rd(CMHS_OFF_TICKS);
            `CHK(q, 32'h3)
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset_n_in = 1'b0;
        element_timing_in = 1'b0;
        char_sent_in = 8'h00;
        do_reset();
        s_reset();
        s_eq();
        s_data();
        s_ext();
        s_slots();
        s_div();
        summarize();
    end
    // Run needs about 3000 cycles; cut a hang well beyond that
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule
bind cmhs_top cmhs_chk cmhs_chk_inst (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .reply_out, .reject_out, .rx_slots_out, .tx_slots_out, .slot_mismatch_out);
